//--- hw/ssz_speed_status.sv
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
// Contract
// RULE1 - Speed mode, lock input, |cmd| <= clamp threshold: hold; leave above
// RULE2 - After leaving hold, follow the present speed command immediately
// RULE3 - Hold runs a position loop within one pulse, command ignored
// RULE4 - Lock input inactive: zero lock disabled, never entered
// RULE5 - Speed mode: match on when |filtered speed - command| <= window
// RULE6 - Match off whenever the difference exceeds the window
// RULE7 - Match held off when not running or not in speed mode
// RULE8 - Reached on when |filtered speed| > reach threshold, else off
// RULE9 - Reached evaluated regardless of run state and mode
// RULE10 - Zero speed on when |filtered speed| < zero threshold
// RULE11 - Zero speed off when |filtered speed| not below threshold
// RULE12 - Zero speed evaluated regardless of run state and mode
// RULE13 - Actual speed low-pass filtered with programmable time constant
// RULE14 - New threshold used at the next evaluation, no stop needed
// RULE15 - All three comparators share one filtered speed value
module ssz_speed_status import ssz_pkg::*; #(
	parameter int SW = SPD_W,
	parameter int PW = POS_W,
	parameter int EVAL_DIV = EVAL_CYCLES
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [DATA_W-1:0] i_pwdata,
	output logic [DATA_W-1:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Drive state
	input wire logic i_run,
	input wire logic [1:0] i_ctrl_mode,
	input wire logic signed [SW-1:0] i_speed_act,
	input wire logic signed [SW-1:0] i_speed_cmd,
	input wire logic signed [PW-1:0] i_enc_pos,
	// Digital input terminal
	input wire logic i_zero_lock_request_input,
	// Speed loop reference
	output logic signed [SW-1:0] o_speed_ref,
	output logic o_zero_locked,
	// Digital output terminals
	output logic o_speed_match,
	output logic o_speed_reached,
	output logic o_zero_speed
);
	// Configuration registers
	logic [15:0] zero_clamp_threshold_q;
	logic [15:0] speed_match_window_q;
	logic [15:0] speed_reach_threshold_q;
	logic [15:0] zero_speed_threshold_q;
	logic [FILT_TC_W-1:0] speed_filter_time_constant_q;

	// Input synchroniser
	logic lock_req_meta_q;
	logic lock_req_q;

	// Evaluation timing
	logic [$clog2(EVAL_DIV+1)-1:0] div_q;
	logic eval_tick;
	logic eval_cmp_q;

	// Shared filtered speed
	logic signed [SW-1:0] filt_spd;
	logic [SW-1:0] filt_abs;

	// Comparator terms
	logic speed_mode;
	logic signed [SW:0] spd_diff;
	logic [SW:0] diff_abs;
	logic match_ok;
	logic reach_ok;
	logic zero_ok;

	// Lock point
	logic signed [PW-1:0] lock_pos;

	// Bus decode
	logic setup_ph;
	logic access_ph;
	logic addr_hit;
	logic addr_hit_q;
	logic [DATA_W-1:0] rd_mux;
	logic wr_en;
	logic [15:0] wr_val;

	// Two flops before any use of the terminal input
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			lock_req_meta_q <= 1'b0;
			lock_req_q <= 1'b0;
		end else begin
			lock_req_meta_q <= i_zero_lock_request_input;
			lock_req_q <= lock_req_meta_q;
		end
	end

	assign speed_mode = i_ctrl_mode == SSZ_MODE_SPD;

	// Evaluation strobe divider
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			div_q <= '0;
		end else if (eval_tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	assign eval_tick = div_q == ($clog2(EVAL_DIV+1))'(EVAL_DIV - 1);

	// Comparators run two cycles after the filter step, when its output settled
	logic eval_d1_q;
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			eval_d1_q <= 1'b0;
			eval_cmp_q <= 1'b0;
		end else begin
			eval_d1_q <= eval_tick;
			eval_cmp_q <= eval_d1_q;
		end
	end

	ssz_speed_filter #(
		.SW(SW)
	) u_filter (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_eval(eval_tick),
		.i_tc(speed_filter_time_constant_q),
		.i_speed(i_speed_act),
		.o_filt(filt_spd),
		.o_abs(filt_abs)
	); // [RULE13] [RULE15]

	ssz_zero_lock #(
		.SW(SW),
		.PW(PW)
	) u_lock (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_speed_mode(speed_mode),
		.i_lock_req(lock_req_q),
		.i_speed_cmd(i_speed_cmd),
		.i_clamp_thr(zero_clamp_threshold_q),
		.i_enc_pos(i_enc_pos),
		.o_locked(o_zero_locked),
		.o_lock_pos(lock_pos),
		.o_speed_ref(o_speed_ref)
	); // [RULE1] [RULE4]

	// Comparisons on the one shared filtered value
	always_comb begin
		spd_diff = (SW+1)'(filt_spd) - (SW+1)'(i_speed_cmd);
		diff_abs = spd_diff[SW] ? (SW+1)'(-spd_diff) : (SW+1)'(spd_diff);
		match_ok = diff_abs <= (SW+1)'(speed_match_window_q); // [RULE5] [RULE6]
		reach_ok = filt_abs > speed_reach_threshold_q; // [RULE8] [RULE15]
		zero_ok = filt_abs < zero_speed_threshold_q; // [RULE10] [RULE11]
	end

	// Match is gated at once when stopped or out of speed mode
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_speed_match <= 1'b0;
		end else if (!i_run || !speed_mode) begin
			o_speed_match <= 1'b0; // [RULE7]
		end else if (eval_cmp_q) begin
			o_speed_match <= match_ok; // [RULE5] [RULE6]
		end
	end

	// No run or mode term here by design
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_speed_reached <= 1'b0;
		end else if (eval_cmp_q) begin
			o_speed_reached <= reach_ok; // [RULE8] [RULE9]
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_zero_speed <= 1'b0;
		end else if (eval_cmp_q) begin
			o_zero_speed <= zero_ok; // [RULE10] [RULE12]
		end
	end

	// APB decode, zero wait states
	assign setup_ph = i_psel && !i_penable;
	assign access_ph = i_psel && i_penable;
	assign o_pready = access_ph;
	assign o_pslverr = access_ph && !addr_hit_q;
	assign wr_en = access_ph && i_pwrite && addr_hit_q;
	assign wr_val = i_pwdata[15:0];

	always_comb begin
		addr_hit = 1'b1;
		rd_mux = '0;
		case (i_paddr)
			OFS_CLAMP_THR: rd_mux[15:0] = zero_clamp_threshold_q;
			OFS_MATCH_WIN: rd_mux[15:0] = speed_match_window_q;
			OFS_REACH_THR: rd_mux[15:0] = speed_reach_threshold_q;
			OFS_ZERO_THR: rd_mux[15:0] = zero_speed_threshold_q;
			OFS_FILT_TC: rd_mux[FILT_TC_W-1:0] = speed_filter_time_constant_q;
			OFS_STATUS: begin
				rd_mux[ST_MATCH] = o_speed_match;
				rd_mux[ST_REACH] = o_speed_reached;
				rd_mux[ST_ZERO] = o_zero_speed;
				rd_mux[ST_LOCKED] = o_zero_locked;
				rd_mux[ST_LOCK_REQ] = lock_req_q;
				rd_mux[ST_RUN] = i_run;
			end
			OFS_FILT_SPD: rd_mux = DATA_W'(filt_spd);
			OFS_LOCK_POS: rd_mux = DATA_W'(lock_pos);
			default: addr_hit = 1'b0;
		endcase
	end

	// Read data captured in the setup cycle so it comes from flops
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_prdata <= '0;
			addr_hit_q <= 1'b0;
		end else if (setup_ph) begin
			o_prdata <= i_pwrite ? '0 : rd_mux;
			addr_hit_q <= addr_hit;
		end
	end

	// Writes saturate into the legal range; live, no stop needed
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			zero_clamp_threshold_q <= RST_CLAMP_THR;
		end else if (wr_en && i_paddr == OFS_CLAMP_THR) begin
			zero_clamp_threshold_q <= (wr_val > CLAMP_THR_MAX) ?
				CLAMP_THR_MAX : wr_val; // [RULE14]
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			speed_match_window_q <= RST_MATCH_WIN;
		end else if (wr_en && i_paddr == OFS_MATCH_WIN) begin
			speed_match_window_q <= (wr_val > MATCH_WIN_MAX) ?
				MATCH_WIN_MAX : wr_val; // [RULE14]
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			speed_reach_threshold_q <= RST_REACH_THR;
		end else if (wr_en && i_paddr == OFS_REACH_THR) begin
			if (wr_val < REACH_THR_MIN) begin
				speed_reach_threshold_q <= REACH_THR_MIN;
			end else if (wr_val > REACH_THR_MAX) begin
				speed_reach_threshold_q <= REACH_THR_MAX;
			end else begin
				speed_reach_threshold_q <= wr_val; // [RULE14]
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			zero_speed_threshold_q <= RST_ZERO_THR;
		end else if (wr_en && i_paddr == OFS_ZERO_THR) begin
			if (wr_val < ZERO_THR_MIN) begin
				zero_speed_threshold_q <= ZERO_THR_MIN;
			end else if (wr_val > ZERO_THR_MAX) begin
				zero_speed_threshold_q <= ZERO_THR_MAX;
			end else begin
				zero_speed_threshold_q <= wr_val; // [RULE14]
			end
		end
	end

	// Filter constant takes effect at the next filter step
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			speed_filter_time_constant_q <= RST_FILT_TC;
		end else if (wr_en && i_paddr == OFS_FILT_TC) begin
			speed_filter_time_constant_q <= i_pwdata[FILT_TC_W-1:0]; // [RULE13]
		end
	end
endmodule // ssz_speed_status

//--- common/ssz_pkg.sv
package ssz_pkg;
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int EVAL_PERIOD_NS = 1000;
	localparam int EVAL_CYCLES = (EVAL_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 :
		EVAL_PERIOD_NS / CLK_PERIOD_NS;

	// Widths
	localparam int SPD_W = 16;
	localparam int POS_W = 32;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int FILT_TC_W = 4;
	localparam int FILT_FRAC = 8;

	// Register byte offsets
	localparam logic [7:0] OFS_CLAMP_THR = 8'h00;
	localparam logic [7:0] OFS_MATCH_WIN = 8'h04;
	localparam logic [7:0] OFS_REACH_THR = 8'h08;
	localparam logic [7:0] OFS_ZERO_THR = 8'h0c;
	localparam logic [7:0] OFS_FILT_TC = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_FILT_SPD = 8'h18;
	localparam logic [7:0] OFS_LOCK_POS = 8'h1c;

	// Reset values
	localparam logic [15:0] RST_CLAMP_THR = 16'h000a;
	localparam logic [15:0] RST_MATCH_WIN = 16'h000a;
	localparam logic [15:0] RST_REACH_THR = 16'h03e8;
	localparam logic [15:0] RST_ZERO_THR = 16'h000a;
	localparam logic [3:0] RST_FILT_TC = 4'h4;

	// Legal ranges
	localparam logic [15:0] CLAMP_THR_MAX = 16'h1770;
	localparam logic [15:0] MATCH_WIN_MAX = 16'h0064;
	localparam logic [15:0] REACH_THR_MIN = 16'h000a;
	localparam logic [15:0] REACH_THR_MAX = 16'h1770;
	localparam logic [15:0] ZERO_THR_MIN = 16'h0001;
	localparam logic [15:0] ZERO_THR_MAX = 16'h1770;

	// Status bit positions
	localparam int ST_MATCH = 0;
	localparam int ST_REACH = 1;
	localparam int ST_ZERO = 2;
	localparam int ST_LOCKED = 3;
	localparam int ST_LOCK_REQ = 4;
	localparam int ST_RUN = 5;

	// Position hold loop
	localparam int LOCK_DEADBAND = 1;
	localparam int LOCK_KP_SHIFT = 2;
	localparam int LOCK_REF_MAX = 3000;

	typedef enum logic [1:0] {
		SSZ_MODE_POS = 2'h0,
		SSZ_MODE_SPD = 2'h1,
		SSZ_MODE_TRQ = 2'h2
	} ssz_mode_t;
endpackage

//--- hw/ssz_speed_filter.sv
`timescale 1ns/1ps
module ssz_speed_filter import ssz_pkg::*; #(
	parameter int SW = SPD_W
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Control
	input wire logic i_eval,
	input wire logic [FILT_TC_W-1:0] i_tc,
	input wire logic signed [SW-1:0] i_speed,
	// Result
	output logic signed [SW-1:0] o_filt,
	output logic [SW-1:0] o_abs
);
	localparam int AW = SW + FILT_FRAC;
	logic signed [AW-1:0] acc_q;
	logic signed [AW:0] diff;
	logic signed [AW:0] step;
	logic signed [SW-1:0] filt;

	// First-order lag, time constant 2^tc evaluation periods [RULE13]
	always_comb begin
		// Sign-extend before scaling so reverse speeds filter correctly
		diff = ((AW+1)'(i_speed) <<< FILT_FRAC) - (AW+1)'(acc_q);
		step = diff >>> i_tc;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			acc_q <= '0;
		end else if (i_eval) begin
			acc_q <= AW'(acc_q + step[AW-1:0]);
		end
	end

	assign filt = acc_q[AW-1:FILT_FRAC];

	// Shared value for every comparator [RULE15]
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_filt <= '0;
			o_abs <= '0;
		end else begin
			o_filt <= filt;
			o_abs <= filt[SW-1] ? SW'(~filt + 1'b1) : filt;
		end
	end
endmodule // ssz_speed_filter

//--- hw/ssz_zero_lock.sv
`timescale 1ns/1ps
module ssz_zero_lock import ssz_pkg::*; #(
	parameter int SW = SPD_W,
	parameter int PW = POS_W
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Conditions
	input wire logic i_speed_mode,
	input wire logic i_lock_req,
	input wire logic signed [SW-1:0] i_speed_cmd,
	input wire logic [15:0] i_clamp_thr,
	input wire logic signed [PW-1:0] i_enc_pos,
	// Results
	output logic o_locked,
	output logic signed [PW-1:0] o_lock_pos,
	output logic signed [SW-1:0] o_speed_ref
);
	typedef enum logic [1:0] {
		ST_FOLLOW = 2'b01,
		ST_HOLD = 2'b10
	} ssz_lock_state_t;

	localparam logic signed [PW+3:0] REF_MAX = (PW+4)'(LOCK_REF_MAX);
	localparam logic signed [PW:0] DEADBAND = (PW+1)'(LOCK_DEADBAND);

	ssz_lock_state_t state_q;
	logic [SW:0] cmd_mag;
	logic small_cmd;
	logic signed [PW:0] err;
	logic signed [PW+3:0] scaled;
	logic signed [SW-1:0] hold_ref;

	always_comb begin
		cmd_mag = i_speed_cmd[SW-1] ? (SW+1)'(-$signed({i_speed_cmd[SW-1],
			i_speed_cmd})) : (SW+1)'(i_speed_cmd);
		small_cmd = cmd_mag <= (SW+1)'(i_clamp_thr);
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			state_q <= ST_FOLLOW;
		end else begin
			case (state_q)
				ST_FOLLOW: begin
					if (i_speed_mode && i_lock_req && small_cmd) begin // [RULE1]
						state_q <= ST_HOLD;
					end
				end
				ST_HOLD: begin
					if (!i_lock_req || !i_speed_mode) begin // [RULE4]
						state_q <= ST_FOLLOW;
					end else if (!small_cmd) begin // [RULE1]
						state_q <= ST_FOLLOW;
					end
				end
				default: state_q <= ST_FOLLOW;
			endcase
		end
	end

	// Lock point is where the shaft sat on entry
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_lock_pos <= '0;
		end else if (state_q == ST_FOLLOW && i_speed_mode && i_lock_req &&
			small_cmd) begin
			o_lock_pos <= i_enc_pos; // [RULE3]
		end
	end

	// Proportional pull-back, quiet inside one pulse [RULE3]
	always_comb begin
		err = (PW+1)'(o_lock_pos) - (PW+1)'(i_enc_pos);
		scaled = (PW+4)'(err) <<< LOCK_KP_SHIFT;
		if (err <= DEADBAND && err >= -DEADBAND) begin
			hold_ref = '0;
		end else if (scaled > REF_MAX) begin
			hold_ref = SW'(REF_MAX);
		end else if (scaled < -REF_MAX) begin
			hold_ref = SW'(-REF_MAX);
		end else begin
			hold_ref = scaled[SW-1:0];
		end
	end

	// Command ignored in hold, followed again at once after [RULE2]
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_speed_ref <= '0;
			o_locked <= 1'b0;
		end else begin
			o_speed_ref <= (state_q == ST_HOLD) ? hold_ref : i_speed_cmd; // [RULE3]
			o_locked <= state_q == ST_HOLD;
		end
	end
endmodule // ssz_zero_lock

//--- tb/ssz_dio_ctrl.sv
`timescale 1ns/1ps
module ssz_dio_ctrl (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Controller side
	input wire logic i_req,
	// Digital input terminal
	output logic o_lock_pin
);
	// Pin changes only after an edge, like a real output stage
	always_ff @(posedge i_sys_clk) begin
		o_lock_pin <= i_rst ? 1'b0 : i_req;
	end
endmodule // ssz_dio_ctrl

//--- tb/ssz_speed_status_sva.sv
`timescale 1ns/1ps
module ssz_speed_status_sva import ssz_pkg::*; #(
	parameter int SW = SPD_W
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// APB
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [DATA_W-1:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	// Drive state
	input wire logic i_run,
	input wire logic [1:0] i_ctrl_mode,
	input wire logic signed [SW-1:0] i_speed_cmd,
	input wire logic i_zero_lock_request_input,
	// Outputs
	input wire logic signed [SW-1:0] o_speed_ref,
	input wire logic o_zero_locked,
	input wire logic o_speed_match
);
	logic mapped;
	assign mapped = (i_paddr <= 8'h1c) && (i_paddr[1:0] == 2'h0);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	a_match_idle_off: assert property ((!i_run || i_ctrl_mode != 2'h1)
		|=> !o_speed_match) else $error("match high while idle");
	a_lock_req_off: assert property ((!i_zero_lock_request_input)[*6]
		|=> !o_zero_locked) else $error("lock without request");
	a_lock_cmd_high: assert property ((i_speed_cmd > 16'sh1770 ||
		i_speed_cmd < -16'sh1770)[*4] |=> !o_zero_locked)
		else $error("lock with large command");
	a_lock_mode_off: assert property ((i_ctrl_mode != 2'h1)[*4]
		|=> !o_zero_locked) else $error("lock outside speed mode");
	a_ref_follows: assert property (($stable(i_speed_cmd) &&
		!o_zero_locked)[*3] |-> o_speed_ref == i_speed_cmd)
		else $error("reference not following command");
	a_hold_ref_limit: assert property (o_zero_locked |->
		o_speed_ref <= 16'sh0bb8 && o_speed_ref >= -16'sh0bb8)
		else $error("hold reference out of limit");
	a_apb_err_map: assert property (i_psel && i_penable |->
		o_pready && (o_pslverr == !mapped)) else $error("bad apb answer");
	a_apb_err_data: assert property (i_psel && i_penable && o_pslverr
		|-> o_prdata == 32'h00000000) else $error("error read not zero");
endmodule // ssz_speed_status_sva
bind ssz_speed_status ssz_speed_status_sva #(.SW(SW)) u_sva (
	.i_sys_clk(i_sys_clk),
	.i_rst(i_rst),
	.i_psel(i_psel),
	.i_penable(i_penable),
	.i_paddr(i_paddr),
	.o_prdata(o_prdata),
	.o_pready(o_pready),
	.o_pslverr(o_pslverr),
	.i_run(i_run),
	.i_ctrl_mode(i_ctrl_mode),
	.i_speed_cmd(i_speed_cmd),
	.i_zero_lock_request_input(i_zero_lock_request_input),
	.o_speed_ref(o_speed_ref),
	.o_zero_locked(o_zero_locked),
	.o_speed_match(o_speed_match)
);

//--- tb/test_speed_status_and_zero_clamp.sv
`timescale 1ns/1ps
module test_speed_status_and_zero_clamp import ssz_pkg::*;;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, run = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, pin, req = 0, locked, match, reached, zero;
	logic [1:0] mode = SSZ_MODE_POS;
	logic signed [15:0] act = 16'sh0, cmd = 16'sh0, sref;
	logic signed [31:0] pos = 32'sh0;
	int errors = 0, n_tests = 0;
	always #5 clk = ~clk;
	ssz_dio_ctrl u_dio (.i_sys_clk(clk), .i_rst(rst), .i_req(req),
		.o_lock_pin(pin));
	ssz_speed_status #(.EVAL_DIV(4)) u_dut (.i_sys_clk(clk), .i_rst(rst),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_run(run),
		.i_ctrl_mode(mode), .i_speed_act(act), .i_speed_cmd(cmd),
		.i_enc_pos(pos), .i_zero_lock_request_input(pin),
		.o_speed_ref(sref), .o_zero_locked(locked),
		.o_speed_match(match), .o_speed_reached(reached),
		.o_zero_speed(zero));
	task give_verdict;
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Waits on pready, never on a fixed count
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(0, a, 32'h0);
		chk(nm, rd, e);
		chk("slverr", {31'h0, er}, 32'h0);
	endtask
	// Settle time covers several evaluations with a zero time constant
	task row(input logic signed [15:0] a, input logic signed [15:0] c,
		input logic r, input logic [1:0] m, input logic [15:0] thr,
		input logic em, input logic er_, input logic ez);
		apb(1, OFS_REACH_THR, {16'h0, thr});
		act <= a;
		cmd <= c;
		run <= r;
		mode <= m;
		cyc(24);
		chk("match", {31'h0, match}, {31'h0, em});
		chk("reached", {31'h0, reached}, {31'h0, er_});
		chk("zero", {31'h0, zero}, {31'h0, ez});
	endtask
	initial begin
		#200000;
		chk("watchdog", 32'h1, 32'h0);
		give_verdict;
	end
	initial begin
		cyc(20);
		rst <= 0;
		rd_chk("clamp", OFS_CLAMP_THR, 32'h0000000a);
		rd_chk("window", OFS_MATCH_WIN, 32'h0000000a);
		rd_chk("reach", OFS_REACH_THR, 32'h000003e8);
		rd_chk("zthr", OFS_ZERO_THR, 32'h0000000a);
		rd_chk("tc", OFS_FILT_TC, 32'h00000004);
		apb(0, 8'h20, 32'h0);
		chk("unmapped", {31'h0, er}, 32'h1);
		apb(1, OFS_MATCH_WIN, 32'h000000c8);
		rd_chk("window sat", OFS_MATCH_WIN, 32'h00000064);
		apb(1, OFS_MATCH_WIN, 32'h0000000a);
		apb(1, OFS_ZERO_THR, 32'h0);
		rd_chk("zthr sat", OFS_ZERO_THR, 32'h00000001);
		apb(1, OFS_ZERO_THR, 32'h0000000a);
		apb(1, OFS_FILT_TC, 32'h0000000f);
		act <= 16'sd4000;
		cyc(20);
		apb(0, OFS_FILT_SPD, 32'h0);
		chk("slow filter", {31'h0, rd < 32'd100}, 32'h1);
		apb(1, OFS_FILT_TC, 32'h0);
		cyc(20);
		rd_chk("fast filter", OFS_FILT_SPD, 32'd4000);
		row(1005, 1000, 1, SSZ_MODE_SPD, 1000, 1, 1, 0);
		row(1010, 1000, 1, SSZ_MODE_SPD, 1000, 1, 1, 0);
		row(1011, 1000, 1, SSZ_MODE_SPD, 1000, 0, 1, 0);
		row(1000, 1000, 1, SSZ_MODE_SPD, 1000, 1, 0, 0);
		row(1500, 1500, 1, SSZ_MODE_SPD, 2000, 1, 0, 0);
		row(-1005, -1000, 1, SSZ_MODE_SPD, 1000, 1, 1, 0);
		row(1005, 1000, 0, SSZ_MODE_SPD, 1000, 0, 1, 0);
		row(5, 0, 1, SSZ_MODE_TRQ, 1000, 0, 0, 1);
		row(10, 0, 0, SSZ_MODE_POS, 1000, 0, 0, 0);
		row(9, 9, 1, SSZ_MODE_SPD, 10, 1, 0, 1);
		row(11, 0, 1, SSZ_MODE_POS, 10, 0, 1, 0);
		act <= 0;
		pos <= 1000;
		cmd <= 5;
		mode <= SSZ_MODE_SPD;
		req <= 1;
		cyc(8);
		chk("locked", {31'h0, locked}, 32'h1);
		chk("hold ref", {16'h0, sref}, 32'h0);
		rd_chk("status", OFS_STATUS, 32'h0000003d);
		rd_chk("lock pos", OFS_LOCK_POS, 32'h000003e8);
		pos <= 1100;
		cyc(4);
		chk("push ref", {16'h0, sref}, 32'h0000fe70);
		pos <= 1001;
		cyc(4);
		chk("deadband", {16'h0, sref}, 32'h0);
		cmd <= 10;
		cyc(4);
		chk("edge lock", {31'h0, locked}, 32'h1);
		cmd <= 11;
		cyc(4);
		chk("unlock", {31'h0, locked}, 32'h0);
		chk("resume", {16'h0, sref}, 32'h0000000b);
		req <= 0;
		cyc(4);
		cmd <= 5;
		cyc(8);
		chk("no req", {31'h0, locked}, 32'h0);
		chk("follow", {16'h0, sref}, 32'h00000005);
		give_verdict;
	end
endmodule // test_speed_status_and_zero_clamp
